// [pkg/mpw_pkg.sv]
// Function
// R1 - Period buffer copies to active period at count reset after match.
// R2 - Up/down modes copy period buffer when count equals zero.
// R3 - Stopped time base copies period buffer continuously.
// R4 - Edge-aligned: active from count zero until duty matches count.
// R5 - Edge-aligned: duty zero never active, duty above period always active.
// R6 - Center-aligned: active on match counting down, inactive on match up.
// R7 - Center-aligned: duty zero never active, duty equal period always.
// R8 - Four 16-bit duty registers; lsb gives half-count edge resolution.
// R9 - Each duty has writable buffer plus separate active compare value.
// R10 - Edge duty update at period wrap, or stopped with hold clear.
// R11 - Up/down duty update at zero turning upward, or when stopped.
// R12 - Double-update mode updates duty at zero and at period match.
// R13 - Complementary: channel n drives pair n, low is complement.
// R14 - Pair mode bits clear means complementary; reset clears them.
// R15 - Six-bit dead-time counter loads on compare edges, blanks both outputs.
// R16 - Dead-time clock is one, two, four or eight cycles.
// R17 - Dead-time prescaler clears on counter load, config write, reset.
// R18 - Software should not change dead-time config while running.
// R19 - Independent pairs have no dead time; both outputs may be active.
// R20 - Independent: duty drives both pins; override gives active or inactive.
// R21 - Single pulse: active at start, off on duty, stop at period.
// R22 - Override register: six select bits high, six levels low.
// R23 - On period match the count resets or reverses next tick.
// R24 - Count register bit 15 reads the down-counting flag.
// R25 - Complementary turn-on edges delayed by dead time; turn-off immediate.
// R26 - Upper duty bits compare to count; lsb shifts edge half count.
package mpw_pkg;
    localparam int CNT_W = 15;
    localparam int DT_W = 6;
    localparam int NUM_DUTY = 4;
    localparam int NUM_PAIR = 3;
    // Register offsets
    localparam logic [3:0] OFF_CTL = 4'h0;
    localparam logic [3:0] OFF_CNT = 4'h1;
    localparam logic [3:0] OFF_PER = 4'h2;
    localparam logic [3:0] OFF_DUTY = 4'h3;
    localparam logic [3:0] OFF_PAIR = 4'h7;
    localparam logic [3:0] OFF_HOLD = 4'h8;
    localparam logic [3:0] OFF_DT = 4'h9;
    localparam logic [3:0] OFF_OVR = 4'hA;
    // Field positions
    localparam int RUN_BIT = 15;
    localparam int DIR_BIT = 15;
    localparam int DT_DIV_LSB = 6;
    localparam int OVR_SEL_LSB = 8;
    // Reset values
    localparam logic [14:0] RST_PERIOD = 15'h0000;
    localparam logic [15:0] RST_DUTY = 16'h0000;
    localparam logic [5:0] RST_OVR = 6'h00;
    localparam logic [5:0] RST_DT = 6'h00;
    localparam logic [2:0] RST_PAIR = 3'h0;
    typedef enum logic [1:0] {
        MPW_FREE, MPW_SINGLE, MPW_UPDOWN, MPW_DOUBLE
    } mpw_mode_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } mpw_bus_t;
endpackage

// [design/mpw_pwm_out.sv]
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mpw_pwm_out (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register port
    input wire mpw_pkg::mpw_bus_t bus_req,
    output logic [15:0] rd_data,
    // Power stage drive
    output logic [2:0] high_side_out,
    output logic [2:0] low_side_out,
    // Events
    output logic single_pulse_done,
    output logic spare_compare
);
////////////////////////////////////////////////////////////////////////////
    // Control state
    logic run_r, run_nxt;
    mpw_pkg::mpw_mode_t mode_r;
    logic [14:0] count_r, count_nxt;
    logic down_r, down_nxt;
    logic half_r;
    logic [14:0] per_buf_r, per_act_r;
    logic hold_r;
    logic [2:0] indep_r;
    logic [5:0] dt_val_r;
    logic [1:0] dt_div_r;
    logic [5:0] ovr_sel_r, ovr_lvl_r;
    logic [15:0] rd_data_r;
    logic done_r;
    logic [2:0] high_r, low_r;
    logic [3:0] cmp;
    logic [15:0] duty_buf_w [4];
    logic [15:0] duty_act_w [4];
    // Assertion clock and reset, ahead of every check
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
////////////////////////////////////////////////////////////////////////////
    // Write decode
    wire wr_ctl = bus_req.wr && bus_req.addr == mpw_pkg::OFF_CTL;
    wire wr_cnt = bus_req.wr && bus_req.addr == mpw_pkg::OFF_CNT;
    wire wr_per = bus_req.wr && bus_req.addr == mpw_pkg::OFF_PER;
    wire wr_pair = bus_req.wr && bus_req.addr == mpw_pkg::OFF_PAIR;
    wire wr_hold = bus_req.wr && bus_req.addr == mpw_pkg::OFF_HOLD;
    wire wr_dt = bus_req.wr && bus_req.addr == mpw_pkg::OFF_DT;
    wire wr_ovr = bus_req.wr && bus_req.addr == mpw_pkg::OFF_OVR;

    // Time base events; one count step every two clocks
    wire edge_mode = mode_r == mpw_pkg::MPW_FREE ||
                     mode_r == mpw_pkg::MPW_SINGLE;
    wire single = mode_r == mpw_pkg::MPW_SINGLE;
    wire tick = run_r && half_r && per_act_r != 15'h0000;
    wire at_per = count_r == per_act_r;
    wire at_zero = count_r == 15'h0000;
    wire wrap = tick && edge_mode && at_per;
    wire [15:0] pos = {count_r, half_r};

    // Period transfer instants
    wire per_load = !run_r || wrap ||                    // see R3 see R1
                    (tick && !edge_mode && at_zero);     // see R2

    // Duty transfer instants; hold blocks running updates, and stopped updates in edge modes
    wire upd_edge = wrap && !hold_r;                     // see R10
    wire upd_ud = tick && down_r && at_zero && !hold_r;  // see R11
    wire upd_dbl = tick && (at_zero || at_per) && !hold_r; // see R12
    wire duty_load = edge_mode ?
                     (upd_edge || (!run_r && !hold_r)) :
                     (mode_r == mpw_pkg::MPW_UPDOWN) ?
                     (upd_ud || !run_r) : (upd_dbl || !run_r);

    // Dead-time prescaler span: 1, 2, 4 or 8 clocks
    wire [3:0] ps_span = 4'h1 << dt_div_r;               // see R16
    wire [2:0] ps_lim = 3'(ps_span - 4'h1);
////////////////////////////////////////////////////////////////////////////
    // Time base next state
    always_comb begin
        count_nxt = count_r;
        down_nxt = down_r;
        run_nxt = run_r;
        if (tick) begin
            if (edge_mode) begin
                if (at_per) begin
                    count_nxt = 15'h0000;                // see R23
                    if (single) begin
                        run_nxt = 1'b0;                  // see R21
                    end
                end else begin
                    count_nxt = count_r + 15'h0001;
                end
            end else if (!down_r) begin
                if (at_per) begin
                    down_nxt = 1'b1;                     // see R23
                    count_nxt = count_r - 15'h0001;
                end else begin
                    count_nxt = count_r + 15'h0001;
                end
            end else if (at_zero) begin
                down_nxt = 1'b0;
                count_nxt = 15'h0001;
            end else begin
                count_nxt = count_r - 15'h0001;
            end
        end
        // Software command wins over the hardware stop
        if (wr_ctl) begin
            run_nxt = bus_req.wdata[mpw_pkg::RUN_BIT];
        end
        if (wr_cnt) begin
            count_nxt = bus_req.wdata[14:0];
        end
    end

    // Time base registers
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            run_r <= 1'b0;
            count_r <= 15'h0000;
            down_r <= 1'b0;
            half_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
            count_r <= count_nxt;
            down_r <= down_nxt;
            half_r <= run_r && !half_r;
        end
    end

    // Mode register; direction flag keeps its value on mode change
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mode_r <= mpw_pkg::MPW_FREE;
        end else if (wr_ctl) begin
            mode_r <= mpw_pkg::mpw_mode_t'(bus_req.wdata[1:0]);
        end
    end

    // Period buffer and active period
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            per_buf_r <= mpw_pkg::RST_PERIOD;
            per_act_r <= mpw_pkg::RST_PERIOD;
        end else begin
            if (wr_per) begin
                per_buf_r <= bus_req.wdata[14:0];
            end
            if (per_load) begin
                per_act_r <= per_buf_r;                  // see R1
            end
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            hold_r <= 1'b0;
            indep_r <= mpw_pkg::RST_PAIR;                // see R14
            dt_val_r <= mpw_pkg::RST_DT;
            dt_div_r <= 2'h0;
            ovr_sel_r <= mpw_pkg::RST_OVR;
            ovr_lvl_r <= mpw_pkg::RST_OVR;
        end else begin
            if (wr_hold) begin
                hold_r <= bus_req.wdata[0];
            end
            if (wr_pair) begin
                indep_r <= bus_req.wdata[2:0];
            end
            if (wr_dt) begin
                dt_val_r <= bus_req.wdata[5:0];
                dt_div_r <= bus_req.wdata[7:6];
            end
            if (wr_ovr) begin
                ovr_sel_r <= bus_req.wdata[13:8];        // see R22
                ovr_lvl_r <= bus_req.wdata[5:0];
            end
        end
    end
////////////////////////////////////////////////////////////////////////////
    // Per-channel duty, compare and pair output logic
    for (genvar i = 0; i < 4; i++) begin : g_ch
        logic [15:0] buf_r, act_r;
        wire [14:0] dh = act_r[15:1];
        wire wr_duty = bus_req.wr &&
                       bus_req.addr == 4'(mpw_pkg::OFF_DUTY + i);
        // Half-count resolution through the phase bit
        wire edge_cmp = pos < act_r;                     // see R4 see R26
        wire center_cmp = act_r != 16'h0000 &&           // see R7
                          (dh == per_act_r ||
                           (down_r ? count_r <= dh : count_r < dh) ||
                           (count_r == dh && act_r[0] && half_r));
        assign duty_buf_w[i] = buf_r;
        assign duty_act_w[i] = act_r;
        // Single pulse stays inactive until run is set
        assign cmp[i] = (single && !run_r) ? 1'b0 :      // see R21
                        edge_mode ? edge_cmp : center_cmp; // see R6

        // Double-buffered duty, glitch-free mid-period
        always_ff @(posedge core_clk) begin
            if (!resetn) begin
                buf_r <= mpw_pkg::RST_DUTY;
                act_r <= mpw_pkg::RST_DUTY;
            end else begin
                if (wr_duty) begin
                    buf_r <= bus_req.wdata;              // see R8
                end
                if (duty_load) begin
                    act_r <= buf_r;                      // see R9
                end
            end
        end

        if (i < 3) begin : g_pair
            logic cmp_d_r;
            logic [5:0] dt_r;
            logic [2:0] ps_r;
            wire cmp_edge = cmp[i] != cmp_d_r;
            // Blank both sides from the edge cycle itself
            wire blank = dt_r != 6'h00 ||                 // see R15
                         (cmp_edge && dt_val_r != 6'h00);
            wire pwm_h = indep_r[i] ? cmp[i] :           // see R19
                         cmp[i] && !blank;               // see R25
            wire pwm_l = indep_r[i] ? cmp[i] :           // see R20
                         !cmp[i] && !blank;              // see R13
            wire h_nxt = ovr_sel_r[2*i+1] ? ovr_lvl_r[2*i+1] : pwm_h;
            wire l_nxt = ovr_sel_r[2*i] ? ovr_lvl_r[2*i] : pwm_l;

            // Dead-time down counter and its prescaler
            always_ff @(posedge core_clk) begin
                if (!resetn) begin
                    cmp_d_r <= 1'b0;
                    dt_r <= 6'h00;
                    ps_r <= 3'h0;                        // see R17
                end else begin
                    cmp_d_r <= cmp[i];
                    if (cmp_edge) begin
                        dt_r <= dt_val_r;                // see R15
                    end else if (dt_r != 6'h00 && ps_r == ps_lim) begin
                        dt_r <= dt_r - 6'h01;
                    end
                    if (cmp_edge || wr_dt || dt_r == 6'h00 ||
                        ps_r == ps_lim) begin
                        ps_r <= 3'h0;                    // see R17
                    end else begin
                        ps_r <= ps_r + 3'h1;
                    end
                end
            end

            // Registered pins keep decode glitches off the bridge
            always_ff @(posedge core_clk) begin
                if (!resetn) begin
                    high_r[i] <= 1'b0;
                    low_r[i] <= 1'b0;
                end else begin
                    high_r[i] <= h_nxt;                  // see R22
                    low_r[i] <= l_nxt;
                end
            end

            // Dead time: no side drives right after a compare edge
            a_deadtime_gap: assert property (            // see R15
                (cmp_edge && dt_val_r != 6'h00 && !indep_r[i] &&
                 ovr_sel_r == 6'h00) |=>
                !high_side_out[i] && !low_side_out[i])
                else $error("pair driven inside dead time");
            a_prescale_clear: assert property (          // see R17
                wr_dt |=> ps_r == 3'h0)
                else $error("dead-time prescaler not cleared");
            a_indep_follow: assert property (            // see R20
                (indep_r[i] && ovr_sel_r == 6'h00) |=>
                high_side_out[i] == $past(cmp[i]) &&
                low_side_out[i] == $past(cmp[i]))
                else $error("independent pair not following duty");
        end
    end
////////////////////////////////////////////////////////////////////////////
    // Read selection; bit 15 of the count is the direction flag
    wire [15:0] rd_mux =
        bus_req.addr == mpw_pkg::OFF_CTL ?
            {run_r, 13'h0000, mode_r} :
        bus_req.addr == mpw_pkg::OFF_CNT ? {down_r, count_r} : // see R24
        bus_req.addr == mpw_pkg::OFF_PER ? {1'b0, per_buf_r} :
        bus_req.addr == 4'h3 ? duty_buf_w[0] :
        bus_req.addr == 4'h4 ? duty_buf_w[1] :
        bus_req.addr == 4'h5 ? duty_buf_w[2] :
        bus_req.addr == 4'h6 ? duty_buf_w[3] :
        bus_req.addr == mpw_pkg::OFF_PAIR ? {13'h0000, indep_r} :
        bus_req.addr == mpw_pkg::OFF_HOLD ? {15'h0000, hold_r} :
        bus_req.addr == mpw_pkg::OFF_DT ?
            {8'h00, dt_div_r, dt_val_r} :
        bus_req.addr == mpw_pkg::OFF_OVR ?
            {2'h0, ovr_sel_r, 2'h0, ovr_lvl_r} : 16'h0000;

    // Read data and event pulses
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rd_data_r <= 16'h0000;
            done_r <= 1'b0;
            spare_compare <= 1'b0;
        end else begin
            rd_data_r <= bus_req.rd ? rd_mux : 16'h0000;
            done_r <= wrap && single;                    // see R21
            spare_compare <= cmp[3];
        end
    end

    assign rd_data = rd_data_r;
    assign single_pulse_done = done_r;
    assign high_side_out = high_r;
    assign low_side_out = low_r;
////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_wrap;
        wrap && !wr_cnt && !wr_per;
    endsequence
    sequence s_single_end;
        wrap && single && !wr_ctl && ovr_sel_r == 6'h00 && !wr_ovr;
    endsequence

    a_period_stopped: assert property (                  // see R3
        (!run_r && !wr_per) |=> per_act_r == $past(per_buf_r))
        else $error("period not copied while stopped");
    a_period_wrap: assert property (                     // see R1
        s_wrap |=> per_act_r == $past(per_buf_r) && count_r == 15'h0000)
        else $error("period wrap missed");
    a_updown_turn: assert property (                     // see R23
        (tick && !edge_mode && !down_r && at_per && !wr_cnt) |=>
        down_r && count_r == $past(count_r) - 15'h0001)
        else $error("up/down did not reverse");
    a_dir_readback: assert property (                    // see R24
        (bus_req.rd && bus_req.addr == mpw_pkg::OFF_CNT) |=>
        rd_data[15] == $past(down_r))
        else $error("direction flag wrong");
    a_single_stop: assert property (                     // see R21
        s_single_end |=> !run_r ##1 high_side_out == 3'h0)
        else $error("single pulse did not end");
    a_edge_zero: assert property (                       // see R5
        (edge_mode && duty_act_w[0] == 16'h0000) |-> !cmp[0])
        else $error("zero duty active");
    a_duty_hold: assert property (                       // see R9
        !duty_load |=> $stable(duty_act_w[1]))
        else $error("active duty changed mid-period");
    a_override_pin: assert property (                    // see R22
        ovr_sel_r[1] |=> high_side_out[0] == $past(ovr_lvl_r[1]))
        else $error("override ignored");
    a_comp_exclusive: assert property (                  // see R13
        ($past(!indep_r[0]) && $past(ovr_sel_r[1:0]) == 2'b00) |->
        !(high_side_out[0] && low_side_out[0]))
        else $error("complementary pair both active");
endmodule
`default_nettype wire

// [dv/mpw_gate_drv.sv]
`timescale 1ns/1ps
`default_nettype none
module mpw_gate_drv (
    // Clock and tally window
    input wire logic core_clk,
    input wire logic clr,
    input wire logic [2:0] comp_mask,
    // Gate drive from the bridge controller
    input wire logic [2:0] high_side_out,
    input wire logic [2:0] low_side_out,
    // Per-leg on-time and both-off gap tallies, plus shoot-through count
    output logic [2:0][15:0] hi_cnt,
    output logic [2:0][15:0] lo_cnt,
    output logic [2:0][15:0] gap_cnt,
    output logic [15:0] shoot_cnt
);
    ////////////////////////////////////////////////////////////////////////
    // Gate tallies; both gates on in a paired leg would short the rail
    always_ff @(posedge core_clk) begin
        for (int k = 0; k < 3; k++) begin
            if (clr) begin
                hi_cnt[k] <= 16'h0000;
                lo_cnt[k] <= 16'h0000;
                gap_cnt[k] <= 16'h0000;
            end else begin
                hi_cnt[k] <= hi_cnt[k] + 16'(high_side_out[k]);
                lo_cnt[k] <= lo_cnt[k] + 16'(low_side_out[k]);
                gap_cnt[k] <= gap_cnt[k]
                    + 16'(!(high_side_out[k] | low_side_out[k]));
            end
        end
        if (clr) begin
            shoot_cnt <= 16'h0000;
        end else begin
            shoot_cnt <= shoot_cnt
                + 16'(|(comp_mask & high_side_out & low_side_out));
        end
    end
endmodule
`default_nettype wire

// [dv/motor_pwm_duty_deadtime_override_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module motor_pwm_duty_deadtime_override_tb;
    logic core_clk;
    logic resetn;
    logic clr;
    logic [2:0] comp_mask;
    mpw_pkg::mpw_bus_t bus_r;
    logic [15:0] rd_data;
    logic [2:0] high_side_out;
    logic [2:0] low_side_out;
    logic single_pulse_done;
    logic spare_compare;
    logic [2:0][15:0] hi_cnt;
    logic [2:0][15:0] lo_cnt;
    logic [2:0][15:0] gap_cnt;
    logic [15:0] shoot_cnt;
    logic [15:0] d;
    logic [15:0] v;
    logic [15:0] per;
    logic [15:0] duty [3];
    logic seen_up;
    logic seen_dn;
    int err_count;
    int checks_done;
    int g;

    mpw_pwm_out dut_u (.core_clk(core_clk), .resetn(resetn),
        .bus_req(bus_r), .rd_data(rd_data),
        .high_side_out(high_side_out), .low_side_out(low_side_out),
        .single_pulse_done(single_pulse_done),
        .spare_compare(spare_compare));
    mpw_gate_drv drv_u (.core_clk(core_clk), .clr(clr),
        .comp_mask(comp_mask), .high_side_out(high_side_out),
        .low_side_out(low_side_out), .hi_cnt(hi_cnt), .lo_cnt(lo_cnt),
        .gap_cnt(gap_cnt), .shoot_cnt(shoot_cnt));

    ////////////////////////////////////////////////////////////////////////
    // Clock, 40 ns period
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Bus cycles; a gap cycle between strobes keeps one assignment a step
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] val);
        @(posedge core_clk);
        bus_r.addr <= a;
        bus_r.wdata <= val;
        bus_r.wr <= 1'b1;
        @(posedge core_clk);
        bus_r.wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] val);
        @(posedge core_clk);
        bus_r.addr <= a;
        bus_r.rd <= 1'b1;
        @(posedge core_clk);
        bus_r.rd <= 1'b0;
        #1;
        val = rd_data;
    endtask

    task automatic clear_cnt();
        @(posedge core_clk);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
    endtask

    task automatic measure(input int n);
        clear_cnt();
        repeat (n) @(posedge core_clk);
        #1;
        chk("shoot", 16'h0000, shoot_cnt);
    endtask

    // Stopped base so period and duties load straight through
    task automatic setup(input logic [15:0] p, input logic [15:0] dtc,
                         input logic [15:0] pair);
        wr_reg(mpw_pkg::OFF_CTL, 16'h0000);
        wr_reg(mpw_pkg::OFF_CNT, 16'h0000);
        wr_reg(mpw_pkg::OFF_PER, p);
        wr_reg(mpw_pkg::OFF_PAIR, pair);
        wr_reg(mpw_pkg::OFF_HOLD, 16'h0000);
        wr_reg(mpw_pkg::OFF_OVR, 16'h0000);
        wr_reg(mpw_pkg::OFF_DT, dtc);
        for (int k = 0; k < 3; k++) begin
            wr_reg(4'(3 + k), duty[k]);
        end
    endtask

    task automatic go(input mpw_pkg::mpw_mode_t m);
        wr_reg(mpw_pkg::OFF_CTL, 16'h8000 | 16'(m));
    endtask

    function automatic logic [15:0] reg_mask(input logic [3:0] a);
        case (a)
            mpw_pkg::OFF_PER: reg_mask = 16'h7FFF;
            mpw_pkg::OFF_PAIR: reg_mask = 16'h0007;
            mpw_pkg::OFF_HOLD: reg_mask = 16'h0001;
            mpw_pkg::OFF_DT: reg_mask = 16'h00FF;
            mpw_pkg::OFF_OVR: reg_mask = 16'h3F3F;
            4'h3, 4'h4, 4'h5, 4'h6: reg_mask = 16'hFFFF;
            default: reg_mask = 16'h0000;
        endcase
    endfunction

    // High time over four edge-aligned periods, clamped at full period
    function automatic logic [15:0] edge_on(input logic [15:0] dv,
                                            input logic [15:0] p);
        edge_on = (dv > 2 * p + 2) ? 16'(8 * p + 8) : 16'(4 * dv);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the few thousand cycles the run needs
    initial begin
        repeat (40000) @(posedge core_clk);
        err_count++;
        stop_test();
    end

    // Main sequence
    initial begin
        resetn = 1'b0;
        clr = 1'b0;
        comp_mask = 3'h0;
        bus_r = '0;
        err_count = 0;
        checks_done = 0;
        void'($urandom(32'h8779));
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        // Reset values, then field widths and unmapped holes
        for (int a = 0; a < 16; a++) begin
            rd_reg(4'(a), d);
            chk("reset reg", 16'h0000, d);
        end
        for (int a = 2; a < 16; a++) begin
            v = 16'($urandom);
            wr_reg(4'(a), v);
            rd_reg(4'(a), d);
            chk("readback", v & reg_mask(4'(a)), d);
        end
        // Edge-aligned duty with zero and above-period corners
        for (int it = 0; it < 3; it++) begin
            per = 16'($urandom_range(40, 8));
            duty[0] = (it == 0) ? 16'h0000 : 16'($urandom_range(2 * per, 1));
            duty[1] = 16'(2 * per + 2 + it);
            duty[2] = 16'($urandom_range(2 * per + 1, 1));
            setup(per, 16'h0000, 16'h0007);
            go(mpw_pkg::MPW_FREE);
            measure(8 * (per + 1));
            for (int k = 0; k < 3; k++) begin
                chk("edge hi", edge_on(duty[k], per), hi_cnt[k]);
                chk("edge lo", edge_on(duty[k], per), lo_cnt[k]);
            end
        end
        // Hold freezes a running duty until released
        wr_reg(mpw_pkg::OFF_HOLD, 16'h0001);
        wr_reg(mpw_pkg::OFF_DUTY, per);
        measure(16 * (per + 1));
        chk("held duty", 2 * edge_on(duty[0], per), hi_cnt[0]);
        wr_reg(mpw_pkg::OFF_HOLD, 16'h0000);
        repeat (2 * (per + 1)) @(posedge core_clk);
        measure(8 * (per + 1));
        chk("new duty", edge_on(per, per), hi_cnt[0]);
        // Running period change lands at the wrap
        wr_reg(mpw_pkg::OFF_PER, per + 16'h0004);
        repeat (4 * (per + 5)) @(posedge core_clk);
        measure(8 * (per + 5));
        chk("new period", edge_on(per, per + 16'h0004), hi_cnt[0]);
        // Dead time for each prescale code on a complementary leg
        per = 16'h001E;
        comp_mask = 3'h7;
        for (int ps = 0; ps < 4; ps++) begin
            v = 16'($urandom_range(3, 1));
            g = 1 + int'(v) * (1 << ps);
            duty = '{16'h001F, 16'h0000, 16'h0000};
            setup(per, 16'(ps << mpw_pkg::DT_DIV_LSB) | v, 16'h0000);
            go(mpw_pkg::MPW_FREE);
            // First period has no high-side turn-on edge to blank
            repeat (62) @(posedge core_clk);
            measure(248);
            chk("dead hi", 16'(4 * (31 - g)), hi_cnt[0]);
            chk("dead lo", 16'(4 * (31 - g)), lo_cnt[0]);
            chk("dead gap", 16'(8 * g), gap_cnt[0]);
            chk("idle lo", 16'h00F8, lo_cnt[1]);
        end
        comp_mask = 3'h0;
        // Manual override on a stopped base
        wr_reg(mpw_pkg::OFF_CTL, 16'h0000);
        wr_reg(mpw_pkg::OFF_PAIR, 16'h0007);
        for (int it = 0; it < 4; it++) begin
            v = 16'($urandom) & 16'h003F;
            wr_reg(mpw_pkg::OFF_OVR, 16'h3F00 | v);
            repeat (3) @(posedge core_clk);
            chk("override", v, 16'({high_side_out[2], low_side_out[2],
                high_side_out[1], low_side_out[1],
                high_side_out[0], low_side_out[0]}));
        end
        // Center-aligned extremes and direction flag, both up/down modes
        per = 16'h0014;
        duty = '{16'h0000, 16'h0028, 16'h0014};
        for (int m = 2; m < 4; m++) begin
            setup(per, 16'h0000, 16'h0007);
            go(mpw_pkg::mpw_mode_t'(m));
            seen_up = 1'b0;
            seen_dn = 1'b0;
            repeat (50) begin
                rd_reg(mpw_pkg::OFF_CNT, d);
                if (d[mpw_pkg::DIR_BIT] === 1'b1) seen_dn = 1'b1;
                if (d[mpw_pkg::DIR_BIT] === 1'b0) seen_up = 1'b1;
            end
            chk("dir flag", 16'h0003, {14'h0000, seen_dn, seen_up});
            measure(320);
            chk("ctr zero", 16'h0000, hi_cnt[0]);
            chk("ctr full", 16'h0140, hi_cnt[1]);
            chk("ctr mid", 16'h0001,
                16'(hi_cnt[2] > 0 && hi_cnt[2] < 320));
        end
        // Single pulse ends itself and clears run
        per = 16'h0010;
        duty = '{16'h000A, 16'h0000, 16'h0000};
        setup(per, 16'h0000, 16'h0007);
        // Arm single mode stopped so no pin is high before the start
        wr_reg(mpw_pkg::OFF_CTL, 16'(mpw_pkg::MPW_SINGLE));
        wr_reg(4'(mpw_pkg::OFF_DUTY + 3), 16'h0005);
        clear_cnt();
        go(mpw_pkg::MPW_SINGLE);
        seen_dn = 1'b0;
        g = 0;
        repeat (100) begin
            @(posedge core_clk);
            #1;
            if (single_pulse_done === 1'b1) seen_dn = 1'b1;
            if (spare_compare === 1'b1) g++;
        end
        chk("pulse done", 16'h0001, 16'(seen_dn));
        chk("spare width", 16'h0005, 16'(g));
        chk("pulse width", 16'h000A, hi_cnt[0]);
        rd_reg(mpw_pkg::OFF_CTL, d);
        chk("run clear", 16'(mpw_pkg::MPW_SINGLE), d);
        stop_test();
    end
endmodule
`default_nettype wire
